// ### tsao_pkg.sv
// package: register map, field positions and reset values of the status/offset block
package tsao_pkg;
	// ==========================================================
	// register addresses
	localparam logic [7:0] TSAO_ADDR_STATUS_ONE   = 8'h02;
	localparam logic [7:0] TSAO_ADDR_ONE_SHOT     = 8'h0f;
	localparam logic [7:0] TSAO_ADDR_R1_OFS_HIGH  = 8'h11;
	localparam logic [7:0] TSAO_ADDR_R1_OFS_LOW   = 8'h12;
	localparam logic [7:0] TSAO_ADDR_STATUS_TWO   = 8'h23;
	localparam logic [7:0] TSAO_ADDR_R2_OFS_HIGH  = 8'h34;
	localparam logic [7:0] TSAO_ADDR_R2_OFS_LOW   = 8'h35;
	// ==========================================================
	// status one bit positions
	localparam int TSAO_S1_BUSY      = 7;
	localparam int TSAO_S1_LOC_HIGH  = 6;
	localparam int TSAO_S1_LOC_LOW   = 5;
	localparam int TSAO_S1_R1_HIGH   = 4;
	localparam int TSAO_S1_R1_LOW    = 3;
	localparam int TSAO_S1_R1_OPEN   = 2;
	localparam int TSAO_S1_R1_OT     = 1;
	localparam int TSAO_S1_LOC_OT    = 0;
	// status two bit positions
	localparam int TSAO_S2_R2_HIGH   = 4;
	localparam int TSAO_S2_R2_LOW    = 3;
	localparam int TSAO_S2_R2_OPEN   = 2;
	localparam int TSAO_S2_R2_OT     = 1;
	localparam int TSAO_S2_EVENT     = 0;
	// ==========================================================
	// offset layout and reset values
	localparam int         TSAO_OFS_W        = 10;
	localparam int         TSAO_OFS_FRAC_W   = 2;
	localparam logic [9:0] TSAO_OFS_RESET    = 10'h000;
	localparam logic [7:0] TSAO_BYTE_ZERO    = 8'h00;
	localparam int         TSAO_NUM_EVT      = 8;
	// ==========================================================
	// one-shot sequencer states
	typedef enum logic [2:0] {
		TSAO_ST_IDLE = 3'b001,
		TSAO_ST_CONV = 3'b010,
		TSAO_ST_DONE = 3'b100
	} tsao_state_t;
endpackage : tsao_pkg

// ### tsao_flag.sv
// sticky flag cell: set by a trip, cleared by a read only once the cause is gone
`timescale 1ns/1ps
`default_nettype none
module tsao_flag (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// cause and clear
	input  wire logic cond_i,
	input  wire logic rd_clr_i,
	// state
	output logic      flag_o
);
	logic flag_reg;
	logic flag_next;

	// a trip in the clear cycle wins; a live cause blocks the clear
	assign flag_next = cond_i | (flag_reg & ~rd_clr_i);

	// flag storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_o = flag_reg;
endmodule // tsao_flag
`default_nettype wire

// ### tsao_top.sv
// status flags, event latch, overtemp outputs, remote offsets and one-shot
// ==========================================================
// Notes on behaviour
// - two read-only status registers at 0x02 and 0x23
// - status one bit 7 shows conversion busy, never raises the event
// - status one bits 6..2 hold local/remote-one limit and open trips, event-capable
// - status one bits 1,0 hold overtemp trips, not event-capable
// - status two bits 7..5 reserved; bits 4..1 remote-two trips
// - event-capable flags stay set until read or reset
// - any set unmasked event flag sets latch, drives event output low
// - reading status one clears bits 6..2 only if their cause is gone
// - reading status two clears bits 4..2 only if their cause is gone
// - event latch clears on alert-response read once cause and flags are gone
// - overtemp output low while s1 bit1, s1 bit0 or s2 bit1 set
// - overtemp bits self-clear when back in limits; output then high
// - overtemp release only below limit minus hysteresis
// - high-limit mode: second output follows high trips only
// - status two bit 0 mirrors the asserted event output, clear if masked
// - offsets are 10-bit two's complement, high byte sign, low byte left-justified
// - offsets at 0x11/0x12 and 0x34/0x35; config bit 3 redirects to remote two
// - offset spans -128 to +127.75 in quarter steps, added to remote readings
// - offsets reset to zero
// - write to 0x0f in standby runs one conversion, data discarded
// - remote-one and remote-two mask bits block their flags from the event
// - local mask bit blocks local flags from the event
`timescale 1ns/1ps
`default_nettype none
module tsao_top
	import tsao_pkg::*;
#(
	parameter int DATA_W = 8
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// register port
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	input  wire logic              alert_resp_i,
	// configuration bits
	input  wire logic              remote_two_select_i,
	input  wire logic              local_event_mask_i,
	input  wire logic              remote_one_event_mask_i,
	input  wire logic              remote_two_event_mask_i,
	input  wire logic              high_limit_mode_i,
	input  wire logic              standby_i,
	// live comparator results
	input  wire logic              local_high_trip_i,
	input  wire logic              local_low_trip_i,
	input  wire logic              remote_one_high_trip_i,
	input  wire logic              remote_one_low_trip_i,
	input  wire logic              remote_one_sensor_open_i,
	input  wire logic              remote_one_overtemp_trip_i,
	input  wire logic              local_overtemp_trip_i,
	input  wire logic              remote_two_high_trip_i,
	input  wire logic              remote_two_low_trip_i,
	input  wire logic              remote_two_sensor_open_i,
	input  wire logic              remote_two_overtemp_trip_i,
	// conversion engine handshake
	input  wire logic              conv_busy_i,
	output logic                   one_shot_start_o,
	output logic [TSAO_OFS_W-1:0]  remote_one_offset_o,
	output logic [TSAO_OFS_W-1:0]  remote_two_offset_o,
	// open-drain pins
	output logic                   event_n_o,
	output logic                   event_oe_o,
	output logic                   overtemp_output_n_o,
	output logic                   overtemp_output_oe_o,
	output logic                   high_limit_overtemp_output_n_o,
	output logic                   high_limit_overtemp_output_oe_o
);
	// ==========================================================
	// elaboration check
	if (DATA_W != 8) begin : g_bad_width
		$error("tsao_top: register data must be 8 bits");
	end

	// ==========================================================
	// address decode
	wire rd_s1     = reg_rd_i & (reg_addr_i == TSAO_ADDR_STATUS_ONE);
	wire rd_s2     = reg_rd_i & (reg_addr_i == TSAO_ADDR_STATUS_TWO);
	wire hit_r1h   = (reg_addr_i == TSAO_ADDR_R1_OFS_HIGH);
	wire hit_r1l   = (reg_addr_i == TSAO_ADDR_R1_OFS_LOW);
	wire hit_r2h   = (reg_addr_i == TSAO_ADDR_R2_OFS_HIGH);
	wire hit_r2l   = (reg_addr_i == TSAO_ADDR_R2_OFS_LOW);
	wire wr_r1h    = reg_wr_i & hit_r1h & ~remote_two_select_i;
	wire wr_r1l    = reg_wr_i & hit_r1l & ~remote_two_select_i;
	wire wr_r2h    = reg_wr_i & ((hit_r1h & remote_two_select_i) | hit_r2h);
	wire wr_r2l    = reg_wr_i & ((hit_r1l & remote_two_select_i) | hit_r2l);
	wire wr_shot   = reg_wr_i & (reg_addr_i == TSAO_ADDR_ONE_SHOT);

	// ==========================================================
	// sticky event-capable flags, one cell per flag
	// order: s1 bits 6..2 then s2 bits 4..2
	wire [TSAO_NUM_EVT-1:0] evt_cond;
	wire [TSAO_NUM_EVT-1:0] evt_clr;
	wire [TSAO_NUM_EVT-1:0] evt_flag;
	wire [TSAO_NUM_EVT-1:0] evt_mask;
	assign evt_cond = {remote_two_sensor_open_i, remote_two_low_trip_i, remote_two_high_trip_i,
		remote_one_sensor_open_i, remote_one_low_trip_i, remote_one_high_trip_i,
		local_low_trip_i, local_high_trip_i};
	assign evt_clr[4:0] = {5{rd_s1}};
	assign evt_clr[7:5] = {3{rd_s2}};
	assign evt_mask[7:2] = {{3{remote_two_event_mask_i}}, {3{remote_one_event_mask_i}}};
	assign evt_mask[1:0] = {2{local_event_mask_i}};

	for (genvar gi = 0; gi < TSAO_NUM_EVT; gi++) begin : g_evt
		tsao_flag u_flag (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.cond_i  (evt_cond[gi]),
			.rd_clr_i(evt_clr[gi]),
			.flag_o  (evt_flag[gi])
		);
	end

	// ==========================================================
	// overtemp flags: follow hysteresis-qualified trips, no read needed
	logic r1_ot_reg;
	logic loc_ot_reg;
	logic r2_ot_reg;
	// trip inputs already carry limit-minus-hysteresis release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r1_ot_reg  <= 1'b0;
			loc_ot_reg <= 1'b0;
			r2_ot_reg  <= 1'b0;
		end else begin
			r1_ot_reg  <= remote_one_overtemp_trip_i;
			loc_ot_reg <= local_overtemp_trip_i;
			r2_ot_reg  <= remote_two_overtemp_trip_i;
		end
	end

	// ==========================================================
	// event latch
	logic event_reg;
	logic event_next;
	wire  evt_any   = |(evt_flag & ~evt_mask);
	wire  evt_clean = ~(|evt_flag) & ~(|(evt_cond & ~evt_mask));
	// alert response releases only when clean
	assign event_next = evt_any | (event_reg & ~(alert_resp_i & evt_clean));

	// event latch storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_reg <= 1'b0;
		end else begin
			event_reg <= event_next;
		end
	end

	// ==========================================================
	// overtemp pins
	logic ot_pin_reg;
	logic hl_pin_reg;
	// overtemp pin from its three flags
	wire ot_any = r1_ot_reg | loc_ot_reg | r2_ot_reg;
	// high-limit mode uses high trips only
	wire hl_any = high_limit_mode_i &
		(evt_flag[0] | evt_flag[2] | evt_flag[5]);

	// pin state registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ot_pin_reg <= 1'b0;
			hl_pin_reg <= 1'b0;
		end else begin
			ot_pin_reg <= ot_any;
			hl_pin_reg <= hl_any;
		end
	end

	// open drain: drive low only when asserted
	assign event_n_o                       = 1'b0;
	assign event_oe_o                      = event_reg;
	assign overtemp_output_n_o             = 1'b0;
	assign overtemp_output_oe_o            = ot_pin_reg;
	assign high_limit_overtemp_output_n_o  = 1'b0;
	assign high_limit_overtemp_output_oe_o = hl_pin_reg;

	// ==========================================================
	// offset registers
	logic [7:0] r1_hi_reg;
	logic [7:0] r1_lo_reg;
	logic [7:0] r2_hi_reg;
	logic [7:0] r2_lo_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r1_hi_reg <= TSAO_BYTE_ZERO;
			r1_lo_reg <= TSAO_BYTE_ZERO;
			r2_hi_reg <= TSAO_BYTE_ZERO;
			r2_lo_reg <= TSAO_BYTE_ZERO;
		end else begin
			if (wr_r1h) r1_hi_reg <= reg_wdata_i;
			if (wr_r2h) r2_hi_reg <= reg_wdata_i;
			// low byte keeps only its top two bits
			if (wr_r1l) r1_lo_reg <= {reg_wdata_i[7:6], 6'h00};
			if (wr_r2l) r2_lo_reg <= {reg_wdata_i[7:6], 6'h00};
		end
	end

	// quarter-degree signed offset handed to the adder
	assign remote_one_offset_o = {r1_hi_reg, r1_lo_reg[7 -: TSAO_OFS_FRAC_W]};
	assign remote_two_offset_o = {r2_hi_reg, r2_lo_reg[7 -: TSAO_OFS_FRAC_W]};

	// ==========================================================
	// one-shot sequencer
	tsao_state_t state_reg;
	tsao_state_t state_next;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TSAO_ST_IDLE: begin
				if (wr_shot && standby_i) state_next = TSAO_ST_CONV;
			end
			TSAO_ST_CONV: begin
				if (conv_busy_i) state_next = TSAO_ST_DONE;
			end
			TSAO_ST_DONE: begin
				if (!conv_busy_i) state_next = TSAO_ST_IDLE;
			end
			default: state_next = TSAO_ST_IDLE;
		endcase
	end

	// sequencer state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= TSAO_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// start held until the engine reports busy
	assign one_shot_start_o = (state_reg == TSAO_ST_CONV);

	// ==========================================================
	// status read image
	logic [7:0] s1_img;
	logic [7:0] s2_img;
	assign s1_img = {conv_busy_i, evt_flag[0], evt_flag[1], evt_flag[2], evt_flag[3],
		evt_flag[4], r1_ot_reg, loc_ot_reg};
	assign s2_img = {3'h0, evt_flag[5], evt_flag[6], evt_flag[7], r2_ot_reg, event_reg};

	// read mux, registered data
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;
	assign rdata_next =
		(reg_addr_i == TSAO_ADDR_STATUS_ONE) ? s1_img :
		(reg_addr_i == TSAO_ADDR_STATUS_TWO) ? s2_img :
		(hit_r1h) ? (remote_two_select_i ? r2_hi_reg : r1_hi_reg) :
		(hit_r1l) ? (remote_two_select_i ? r2_lo_reg : r1_lo_reg) :
		(hit_r2h) ? r2_hi_reg :
		(hit_r2l) ? r2_lo_reg : TSAO_BYTE_ZERO;

	// read data capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= TSAO_BYTE_ZERO;
		end else if (reg_rd_i) begin
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata_o = rdata_reg;

	// ==========================================================
	// checks
	// latch follows unmasked flag
	property p_event_set;
		@(posedge clk_i) disable iff (rst_i) evt_any |=> event_oe_o;
	endproperty
	a_event_set: assert property (p_event_set) else $error("event not raised");

	property p_event_hold;
		@(posedge clk_i) disable iff (rst_i)
			(event_reg && !alert_resp_i) |=> event_reg;
	endproperty
	a_event_hold: assert property (p_event_hold) else $error("event dropped");

	property p_flag_sticky;
		@(posedge clk_i) disable iff (rst_i)
			(evt_flag[0] && !rd_s1) |=> evt_flag[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

	property p_no_clear_live;
		@(posedge clk_i) disable iff (rst_i)
			(rd_s2 && remote_two_high_trip_i) |=> evt_flag[5];
	endproperty
	a_no_clear_live: assert property (p_no_clear_live) else $error("live flag cleared");

	property p_ot_pin;
		@(posedge clk_i) disable iff (rst_i)
			local_overtemp_trip_i |-> ##2 overtemp_output_oe_o;
	endproperty
	a_ot_pin: assert property (p_ot_pin) else $error("overtemp pin late");

	property p_ot_release;
		@(posedge clk_i) disable iff (rst_i)
			(!remote_one_overtemp_trip_i && !local_overtemp_trip_i
			 && !remote_two_overtemp_trip_i)[*2] |=> !overtemp_output_oe_o;
	endproperty
	a_ot_release: assert property (p_ot_release) else $error("overtemp stuck");

	// the read path must return the pin state seen when the read was taken
	property p_mirror;
		@(posedge clk_i) disable iff (rst_i)
			rd_s2 |=> (reg_rdata_o[TSAO_S2_EVENT] == $past(event_oe_o));
	endproperty
	a_mirror: assert property (p_mirror) else $error("event mirror wrong");

	sequence s_shot_req;
		wr_shot && standby_i && state_reg == TSAO_ST_IDLE;
	endsequence
	property p_shot;
		@(posedge clk_i) disable iff (rst_i) s_shot_req |=> one_shot_start_o;
	endproperty
	a_shot: assert property (p_shot) else $error("one-shot not started");

	// low byte write keeps the two quarter bits, the rest reads zero
	property p_ofs_low;
		@(posedge clk_i) disable iff (rst_i)
			wr_r1l |=> (r1_lo_reg == {$past(reg_wdata_i[7:6]), 6'h00});
	endproperty
	a_ofs_low: assert property (p_ofs_low) else $error("offset low bits set");
endmodule // tsao_top
`default_nettype wire

// ### tsao_host_model.sv
// host controller model: register reads, writes and alert-response reads
`timescale 1ns/1ps
`default_nettype none
module tsao_host_model (
	// clock
	input  wire logic       clk_i,
	// register port towards the device
	output logic      [7:0] reg_addr_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i,
	output logic            alert_resp_o
);
	// ==========================================================
	// idle bus: strobes low, address and data scrambled
	initial begin
		reg_addr_o   = 8'hff;
		reg_wr_o     = 1'b0;
		reg_rd_o     = 1'b0;
		reg_wdata_o  = 8'h5a;
		alert_resp_o = 1'b0;
	end
	// single-cycle register write
	// data goes with every write, even where it is thrown away
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o  = a;
		reg_wdata_o = d;
		reg_wr_o    = 1'b1;
		@(negedge clk_i);
		reg_wr_o    = 1'b0;
		// released lines must not keep looking valid
		reg_wdata_o = ~d;
		reg_addr_o  = ~a;
	endtask
	// registered answer is taken one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_rd_o   = 1'b1;
		@(negedge clk_i);
		d          = reg_rdata_i;
		reg_rd_o   = 1'b0;
		reg_addr_o = ~a;
	endtask
	task automatic ack();
		@(negedge clk_i);
		alert_resp_o = 1'b1;
		@(negedge clk_i);
		alert_resp_o = 1'b0;
	endtask
endmodule // tsao_host_model
`default_nettype wire

// ### tsao_top_tb.sv
// self-checking bench for status flags, event, overtemp pins, offsets, one-shot
`timescale 1ns/1ps
`default_nettype none
module tsao_top_tb;
	import tsao_pkg::*;
	typedef struct packed {
		logic [3:0] idx;
		logic [7:0] addr, on, r1, r2;
		logic [2:0] pon, poff;
	} tsao_row_t;
	// ==========================================================
	// signals; sts[7:0] feed status one causes, sts[12:9] status two
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr, wdata, rdata;
	logic        wr, rd, ack, start;
	logic [12:0] sts = 13'h0000;
	logic [2:0]  msk = 3'h0;
	logic        sel = 1'b0;
	logic        hmode = 1'b0;
	logic        stby = 1'b0;
	logic [9:0]  ofs1, ofs2;
	wire  [5:0]  pin;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	// rows: cause index, status address, reads, pins {high-limit, overtemp, event}
	tsao_row_t rows [11] = '{
		'{4'h6, 8'h02, 8'h40, 8'h40, 8'h00, 3'h1, 3'h1},
		'{4'h5, 8'h02, 8'h20, 8'h20, 8'h00, 3'h1, 3'h1},
		'{4'h4, 8'h02, 8'h10, 8'h10, 8'h00, 3'h1, 3'h1},
		'{4'h3, 8'h02, 8'h08, 8'h08, 8'h00, 3'h1, 3'h1},
		'{4'h2, 8'h02, 8'h04, 8'h04, 8'h00, 3'h1, 3'h1},
		'{4'h1, 8'h02, 8'h02, 8'h00, 8'h00, 3'h2, 3'h0},
		'{4'h0, 8'h02, 8'h01, 8'h00, 8'h00, 3'h2, 3'h0},
		'{4'hc, 8'h23, 8'h11, 8'h11, 8'h01, 3'h1, 3'h1},
		'{4'hb, 8'h23, 8'h09, 8'h09, 8'h01, 3'h1, 3'h1},
		'{4'ha, 8'h23, 8'h05, 8'h05, 8'h01, 3'h1, 3'h1},
		'{4'h9, 8'h23, 8'h02, 8'h00, 8'h00, 3'h2, 3'h0}};
	// ==========================================================
	// clock, hang guard
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			stop_test();
		end
	end
	tsao_host_model host (.clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata), .alert_resp_o(ack));
	tsao_top dut (.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .alert_resp_i(ack),
		.remote_two_select_i(sel), .local_event_mask_i(msk[0]),
		.remote_one_event_mask_i(msk[1]), .remote_two_event_mask_i(msk[2]),
		.high_limit_mode_i(hmode), .standby_i(stby),
		.local_high_trip_i(sts[6]), .local_low_trip_i(sts[5]),
		.remote_one_high_trip_i(sts[4]), .remote_one_low_trip_i(sts[3]),
		.remote_one_sensor_open_i(sts[2]), .remote_one_overtemp_trip_i(sts[1]),
		.local_overtemp_trip_i(sts[0]), .remote_two_high_trip_i(sts[12]),
		.remote_two_low_trip_i(sts[11]), .remote_two_sensor_open_i(sts[10]),
		.remote_two_overtemp_trip_i(sts[9]), .conv_busy_i(sts[7]),
		.one_shot_start_o(start), .remote_one_offset_o(ofs1), .remote_two_offset_o(ofs2),
		.event_n_o(pin[0]), .event_oe_o(pin[1]), .overtemp_output_n_o(pin[2]),
		.overtemp_output_oe_o(pin[3]), .high_limit_overtemp_output_n_o(pin[4]),
		.high_limit_overtemp_output_oe_o(pin[5]));
	// ==========================================================
	// shared helpers
	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		host.rd(a, v);
		chk({2'h0, v}, {2'h0, e});
	endtask
	// pin enables as {high-limit, overtemp, event}
	task automatic pchk(input logic [2:0] e);
		chk({7'h00, pin[5], pin[3], pin[1]}, {7'h00, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		tsao_row_t r;
		int        idx;
		tick(4);
		rst = 1'b0;
		// flag rows: raise, read while live, drop, ack too early, read twice, ack
		foreach (rows[k]) begin
			r = rows[k];
			sts[r.idx] = 1'b1;
			tick(3);
			pchk(r.pon);
			rchk(r.addr, r.on);
			sts[r.idx] = 1'b0;
			tick(3);
			host.ack();
			tick(2);
			pchk(r.poff);
			rchk(r.addr, r.r1);
			rchk(r.addr, r.r2);
			rchk(TSAO_ADDR_STATUS_TWO, {7'h00, r.poff[0]});
			host.ack();
			tick(2);
			pchk(3'h0);
			$display("test row %0d done", k);
		end
		chk({7'h00, pin[4], pin[2], pin[0]}, 10'h000);
		// offsets: zero at reset, sign and quarter steps, redirect
		rchk(TSAO_ADDR_R1_OFS_HIGH, 8'h00);
		host.wr(TSAO_ADDR_R1_OFS_HIGH, 8'h80);
		host.wr(TSAO_ADDR_R1_OFS_LOW, 8'h40);
		host.wr(TSAO_ADDR_R2_OFS_HIGH, 8'hff);
		host.wr(TSAO_ADDR_R2_OFS_LOW, 8'h80);
		tick(1);
		chk(ofs1, 10'h201);
		chk(ofs2, 10'h3fe);
		rchk(TSAO_ADDR_R2_OFS_LOW, 8'h80);
		sel = 1'b1;
		host.wr(TSAO_ADDR_R1_OFS_HIGH, 8'h7f);
		host.wr(TSAO_ADDR_R1_OFS_LOW, 8'hff);
		tick(1);
		chk(ofs2, 10'h1ff);
		chk(ofs1, 10'h201);
		rchk(TSAO_ADDR_R1_OFS_HIGH, 8'h7f);
		sel = 1'b0;
		rchk(TSAO_ADDR_R1_OFS_HIGH, 8'h80);
		$display("test offsets done");
		// status writes refused, unmapped read, busy bit
		host.wr(TSAO_ADDR_STATUS_ONE, 8'hff);
		host.wr(TSAO_ADDR_STATUS_TWO, 8'hff);
		rchk(TSAO_ADDR_STATUS_ONE, 8'h00);
		rchk(TSAO_ADDR_STATUS_TWO, 8'h00);
		rchk(8'h40, 8'h00);
		sts[7] = 1'b1;
		tick(2);
		rchk(TSAO_ADDR_STATUS_ONE, 8'h80);
		pchk(3'h0);
		sts[7] = 1'b0;
		$display("test refusals done");
		// masks hold the event back, flag stays readable
		for (int j = 0; j < 3; j++) begin
			idx = (j == 0) ? 6 : ((j == 1) ? 4 : 12);
			msk[j] = 1'b1;
			sts[idx] = 1'b1;
			tick(1);
			sts[idx] = 1'b0;
			tick(3);
			pchk(3'h0);
			rchk((idx < 8) ? TSAO_ADDR_STATUS_ONE : TSAO_ADDR_STATUS_TWO, 8'h01 << (idx % 8));
			rchk(TSAO_ADDR_STATUS_TWO, 8'h00);
			msk[j] = 1'b0;
			tick(3);
			pchk(3'h0);
		end
		$display("test masks done");
		// high-limit mode: low trips ignored, high trips drive the pin
		hmode = 1'b1;
		sts[5] = 1'b1;
		tick(1);
		sts[5] = 1'b0;
		tick(3);
		pchk(3'h1);
		sts[4] = 1'b1;
		tick(1);
		sts[4] = 1'b0;
		tick(3);
		pchk(3'h5);
		rchk(TSAO_ADDR_STATUS_ONE, 8'h30);
		tick(2);
		pchk(3'h1);
		host.ack();
		tick(2);
		pchk(3'h0);
		hmode = 1'b0;
		$display("test high limit done");
		host.wr(TSAO_ADDR_ONE_SHOT, 8'ha5);
		chk({9'h000, start}, 10'h000);
		stby = 1'b1;
		host.wr(TSAO_ADDR_ONE_SHOT, 8'h3c);
		chk({9'h000, start}, 10'h001);
		tick(2);
		chk({9'h000, start}, 10'h001);
		sts[7] = 1'b1;
		tick(2);
		sts[7] = 1'b0;
		tick(3);
		chk({9'h000, start}, 10'h000);
		stby = 1'b0;
		$display("test one-shot done");
		// reset in mid-run clears offsets and flags
		sts[6] = 1'b1;
		tick(1);
		sts[6] = 1'b0;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		chk(ofs1, 10'h000);
		chk(ofs2, 10'h000);
		pchk(3'h0);
		rchk(TSAO_ADDR_STATUS_ONE, 8'h00);
		$display("test reset done");
		stop_test();
	end
endmodule // tsao_top_tb
`default_nettype wire
